// ---- hw/tsr_rewrite_top.sv ----
// How it works
// - ingress ptp sync/delay_req: write into reserved bytes
// - ingress write puts nanoseconds, then new fcs
// - ingress sync: stamp minus correction, cf plus asymmetry
// - egress ptp: write-save, offset and size zero
// - egress id to fifo holds sequence id
// - egress ptp zeroes the reserved header field
// - write-save sends stamp to fifo, sets save
// - fifo keeps stamp with frame identifier
// - egress fifo value plus correction, delay_req minus asymmetry
// - ingress 1dm/dmm/dmr stamp the receive field
// - egress 1dm/dmm stamp forward transmit field
// - egress dmr stamp backward transmit field
// - delay measurement write then fcs recompute
// - ingress oam stamp is time minus correction
// - egress oam stamp is time plus correction
// - optional receive stamp kept in fifo entry
// - unmatched frames pass, stamp discarded
// - frame length and gaps kept unchanged
// - time captured at start of frame
`timescale 1ns/1ps
module tsr_rewrite_top
  import tsr_pkg::*;
#(
  parameter int DLY   = DELAY_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // configuration
  input  wire logic               egressDir,
  input  wire logic [7:0]         cfgDomain,
  input  wire logic [2:0]         cfgMepLevel,
  input  wire logic [NS_W-1:0]    localCorrection,
  input  wire logic [NS_W-1:0]    asymmetry,
  input  wire logic               saveRxStamp,
  // local time
  input  wire logic [TIME_W-1:0]  localTime,
  // incoming byte stream
  input  wire logic [DATA_W-1:0]  inData,
  input  wire logic               inValid,
  input  wire logic               inSof,
  input  wire logic               inEof,
  output logic                    streamReady,
  // outgoing byte stream
  output logic [DATA_W-1:0]       outData,
  output logic                    outValid,
  output logic                    outSof,
  output logic                    outEof,
  // transmit stamp queue
  output logic [ENTRY_W-1:0]      tsData,
  output logic                    tsValid,
  input  wire logic               tsReady
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic inRange(input logic [6:0] p, input logic [6:0] b,
                                   input logic [3:0] n);
    return (int'(p) >= int'(b)) && (int'(p) < int'(b) + int'(n));
  endfunction

  function automatic logic [6:0] posStep(input logic [6:0] p);
    return (p == 7'h7f) ? p : p + 7'h01;
  endfunction

  function automatic logic [7:0] pickByte(input logic [63:0] v, input logic [2:0] i);
    return v[{i, 3'b000} +: 8];
  endfunction

  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // input position and field capture
  // ---------------------------------------------------------------
  logic [6:0]        inCnt_r;
  logic [6:0]        inPos;
  logic [TIME_W-1:0] capTime_r;
  logic [15:0]       etype_r;
  logic [7:0]        msgByte_r;
  logic [7:0]        opcode_r;
  logic [7:0]        domain_r;
  logic [63:0]       corr_r;
  logic [31:0]       resv_r;
  logic [15:0]       port_r;
  logic [15:0]       seq_r;

  assign inPos = inSof ? 7'h00 : inCnt_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      inCnt_r <= '0;
    end else if (inValid) begin
      inCnt_r <= posStep(inPos);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      capTime_r <= '0;
    end else if (inValid && inSof) begin
      capTime_r <= localTime;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      etype_r   <= '0;
      msgByte_r <= '0;
      opcode_r  <= '0;
      domain_r  <= '0;
      corr_r    <= '0;
      resv_r    <= '0;
      port_r    <= '0;
      seq_r     <= '0;
    end else if (inValid) begin
      if (inRange(inPos, POS_ETYPE, 4'h2)) etype_r <= {etype_r[7:0], inData};
      if (inPos == POS_MSG) msgByte_r <= inData;
      if (inPos == POS_OPC) opcode_r <= inData;
      if (inPos == POS_DOMAIN) domain_r <= inData;
      if (inRange(inPos, POS_CORR, SIZE_TS)) corr_r <= {corr_r[55:0], inData};
      if (inRange(inPos, POS_RESV, SIZE_NS)) resv_r <= {resv_r[23:0], inData};
      if (inRange(inPos, POS_PORT, 4'h2)) port_r <= {port_r[7:0], inData};
      if (inRange(inPos, POS_SEQ, 4'h2)) seq_r <= {seq_r[7:0], inData};
    end
  end

  // ---------------------------------------------------------------
  // analyzer
  // ---------------------------------------------------------------
  logic       ptpHit;
  logic       oamHit;
  logic       isSync;
  logic       decide;
  tsr_act_t   act_r;
  logic [6:0] wrOff_r;
  logic [3:0] wrSize_r;
  logic       zeroResv_r;
  logic       corrAdd_r;
  logic [63:0] stamp_r;
  logic [63:0] corrNew_r;
  logic [NS_W-1:0] nsSub;
  logic [NS_W-1:0] nsAdd;

  assign isSync = (msgByte_r[3:0] == MSG_SYNC);
  assign ptpHit = (etype_r == ETYPE_PTP) && (domain_r == cfgDomain)
                  && (isSync || msgByte_r[3:0] == MSG_DREQ);
  assign oamHit = (etype_r == ETYPE_OAM) && (msgByte_r[7:5] == cfgMepLevel)
                  && (opcode_r == OP_1DM || opcode_r == OP_DMM || opcode_r == OP_DMR);
  assign decide = inValid && (inPos == POS_DECIDE);
  assign nsSub  = capTime_r[NS_W-1:0] - localCorrection;
  assign nsAdd  = capTime_r[NS_W-1:0] + localCorrection;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act_r      <= ACT_NONE;
      wrOff_r    <= '0;
      wrSize_r   <= SIZE_NONE;
      zeroResv_r <= 1'b0;
      corrAdd_r  <= 1'b0;
      stamp_r    <= '0;
    end else if (decide) begin
      act_r      <= ACT_NONE;
      wrOff_r    <= '0;
      wrSize_r   <= SIZE_NONE;
      zeroResv_r <= 1'b0;
      corrAdd_r  <= 1'b0;
      stamp_r    <= '0;
      if (ptpHit && !egressDir) begin
        act_r     <= ACT_WRITE;
        wrOff_r   <= POS_RESV;
        wrSize_r  <= SIZE_NS;
        corrAdd_r <= isSync;
        stamp_r   <= {capTime_r[TIME_W-1:NS_W], nsSub};
      end else if (ptpHit) begin
        act_r      <= ACT_WRSAVE;
        zeroResv_r <= 1'b1;
        stamp_r    <= {capTime_r[TIME_W-1:NS_W], isSync ? nsAdd : nsAdd - asymmetry};
      end else if (oamHit && !egressDir) begin
        act_r    <= ACT_WRITE;
        wrOff_r  <= (opcode_r == OP_DMR) ? POS_RXB : POS_RXF;
        wrSize_r <= SIZE_TS;
        stamp_r  <= {capTime_r[TIME_W-1:NS_W], nsSub};
      end else if (oamHit) begin
        act_r    <= ACT_WRITE;
        wrOff_r  <= (opcode_r == OP_DMR) ? POS_TXB : POS_TXF;
        wrSize_r <= SIZE_TS;
        stamp_r  <= {capTime_r[TIME_W-1:NS_W], nsAdd};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      corrNew_r <= '0;
    end else if (inValid && inPos == POS_RESV) begin
      corrNew_r <= corr_r + {{32{asymmetry[31]}}, asymmetry};
    end
  end

  // ---------------------------------------------------------------
  // stamp queue feed
  // ---------------------------------------------------------------
  tsr_fifo_if #(.WIDTH(ENTRY_W)) tsq ();
  logic               pushPend_r;
  logic [ENTRY_W-1:0] pushData_r;
  logic               pushNow;

  assign pushNow     = inValid && (inPos == POS_ID_END) && (act_r == ACT_WRSAVE);
  assign tsq.wrValid = pushPend_r;
  assign tsq.wrData  = pushData_r;
  assign tsq.rdReady = tsReady;
  assign tsData      = tsq.rdData;
  assign tsValid     = tsq.rdValid;
  assign streamReady = !pushPend_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pushPend_r <= 1'b0;
      pushData_r <= '0;
    end else if (pushNow) begin
      pushPend_r <= 1'b1;
      pushData_r <= {stamp_r[NS_W-1:0], saveRxStamp ? resv_r : 32'h00000000,
                     seq_r, port_r, domain_r, 4'h0, msgByte_r[3:0]};
    end else if (tsq.wrReady) begin
      pushPend_r <= 1'b0;
    end
  end

  tsr_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst (rst),
    .q   (tsq.store)
  );

  // ---------------------------------------------------------------
  // delay line
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] dlData [DLY];
  logic [DLY-1:0]    dlVal;
  logic [DLY-1:0]    dlSof;
  logic [DLY-1:0]    dlEof;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DLY; i++) dlData[i] <= '0;
      dlVal <= '0;
      dlSof <= '0;
      dlEof <= '0;
    end else begin
      dlData[0] <= inData;
      for (int i = 1; i < DLY; i++) dlData[i] <= dlData[i-1];
      dlVal <= {dlVal[DLY-2:0], inValid};
      dlSof <= {dlSof[DLY-2:0], inValid && inSof};
      dlEof <= {dlEof[DLY-2:0], inValid && inEof};
    end
  end

  // ---------------------------------------------------------------
  // rewriter
  // ---------------------------------------------------------------
  logic [6:0]  outCnt_r;
  logic [6:0]  outPos;
  logic [31:0] crc_r;
  logic [7:0]  byteNxt;
  logic        fcsZone;
  logic [1:0]  fcsIdx;
  logic        modNxt;
  logic        modOut_r;

  assign outPos = dlSof[DLY-1] ? 7'h00 : outCnt_r;

  always_comb begin
    fcsZone = 1'b0;
    fcsIdx  = 2'b00;
    for (int k = 0; k < FCS_LEN; k++) begin
      if (dlEof[DLY-1-k]) begin
        fcsZone = 1'b1;
        fcsIdx  = 2'(FCS_LEN - 1 - k);
      end
    end
  end

  always_comb begin
    byteNxt = dlData[DLY-1];
    modNxt  = (act_r != ACT_NONE);
    if (act_r != ACT_NONE && inRange(outPos, wrOff_r, wrSize_r)) begin
      byteNxt = pickByte(stamp_r, 3'(wrSize_r - 4'h1 - 4'(outPos - wrOff_r)));
    end
    if (zeroResv_r && inRange(outPos, POS_RESV, SIZE_NS)) begin
      byteNxt = 8'h00;
    end
    if (corrAdd_r && inRange(outPos, POS_CORR, SIZE_TS)) begin
      byteNxt = pickByte(corrNew_r, 3'(4'h7 - 4'(outPos - POS_CORR)));
    end
    if (modNxt && fcsZone) begin
      byteNxt = pickByte({32'h00000000, ~crc_r}, {1'b0, fcsIdx});
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outCnt_r <= '0;
      crc_r    <= CRC_INIT;
    end else if (dlVal[DLY-1]) begin
      outCnt_r <= posStep(outPos);
      if (!fcsZone) begin
        crc_r <= crcByte(dlSof[DLY-1] ? CRC_INIT : crc_r, byteNxt);
      end
    end
  end

  // one byte out per byte in
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outData  <= '0;
      outValid <= 1'b0;
      outSof   <= 1'b0;
      outEof   <= 1'b0;
      modOut_r <= 1'b0;
    end else begin
      outData  <= byteNxt;
      outValid <= dlVal[DLY-1];
      outSof   <= dlSof[DLY-1];
      outEof   <= dlEof[DLY-1];
      modOut_r <= modNxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_len_kept: assert property (@(posedge mclk) disable iff (rst)
    outValid == $past(inValid, DLY + 1) && outSof == $past(inValid && inSof, DLY + 1))
    else $error("stream shape changed");
  a_pass_through: assert property (@(posedge mclk) disable iff (rst)
    outValid && !modOut_r |-> outData == $past(inData, DLY + 1))
    else $error("unmatched frame modified");
  a_time_capture: assert property (@(posedge mclk) disable iff (rst)
    inValid && inSof |=> capTime_r == $past(localTime))
    else $error("time not captured at sof");
  a_ing_ptp_write: assert property (@(posedge mclk) disable iff (rst)
    decide && ptpHit && !egressDir
    |=> act_r == ACT_WRITE && wrOff_r == POS_RESV && wrSize_r == SIZE_NS)
    else $error("ingress ptp action wrong");
  a_egr_ptp_save: assert property (@(posedge mclk) disable iff (rst)
    decide && ptpHit && egressDir
    |=> act_r == ACT_WRSAVE && wrSize_r == SIZE_NONE && zeroResv_r)
    else $error("egress ptp action wrong");
  a_ing_oam_stamp: assert property (@(posedge mclk) disable iff (rst)
    decide && oamHit && !egressDir
    |=> stamp_r[NS_W-1:0] == $past(capTime_r[NS_W-1:0] - localCorrection))
    else $error("ingress oam stamp wrong");
  a_egr_oam_stamp: assert property (@(posedge mclk) disable iff (rst)
    decide && oamHit && egressDir
    |=> stamp_r[NS_W-1:0] == $past(capTime_r[NS_W-1:0] + localCorrection))
    else $error("egress oam stamp wrong");
  a_fifo_entry: assert property (@(posedge mclk) disable iff (rst)
    pushNow |=> pushPend_r && pushData_r[ENTRY_W-1 -: NS_W] == $past(stamp_r[NS_W-1:0])
    && pushData_r[47:32] == $past(seq_r))
    else $error("queue entry wrong");
  a_resv_zeroed: assert property (@(posedge mclk) disable iff (rst)
    dlVal[DLY-1] && zeroResv_r && inRange(outPos, POS_RESV, SIZE_NS) && !fcsZone
    |=> outData == 8'h00)
    else $error("reserved field not cleared");

  c_ing_write: cover property (@(posedge mclk) disable iff (rst)
    decide && ptpHit && !egressDir);
  c_egr_save: cover property (@(posedge mclk) disable iff (rst) pushNow);
  c_oam_egress: cover property (@(posedge mclk) disable iff (rst)
    decide && oamHit && egressDir);
  c_queue_full: cover property (@(posedge mclk) disable iff (rst)
    pushPend_r && !tsq.wrReady);
endmodule

// ---- hw/tsr_pkg.sv ----
package tsr_pkg;
  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int TIME_W     = 64;
  localparam int NS_W       = 32;
  localparam int ID_W       = 80;
  localparam int ENTRY_W    = NS_W + ID_W;
  localparam int FIFO_DEPTH = 8;
  localparam int DELAY_CYC  = 16;
  localparam int POS_W      = 7;
  localparam int FCS_LEN    = 4;

  // ---------------------------------------------------------------
  // frame codes
  // ---------------------------------------------------------------
  localparam logic [15:0] ETYPE_PTP = 16'h88f7;
  localparam logic [15:0] ETYPE_OAM = 16'h8902;
  localparam logic [3:0]  MSG_SYNC  = 4'h0;
  localparam logic [3:0]  MSG_DREQ  = 4'h1;
  localparam logic [7:0]  OP_1DM    = 8'h2d;
  localparam logic [7:0]  OP_DMR    = 8'h2e;
  localparam logic [7:0]  OP_DMM    = 8'h2f;

  // ---------------------------------------------------------------
  // byte positions from the first destination address byte
  // ---------------------------------------------------------------
  localparam logic [6:0] POS_ETYPE  = 7'h0c;
  localparam logic [6:0] POS_MSG    = 7'h0e;
  localparam logic [6:0] POS_OPC    = 7'h0f;
  localparam logic [6:0] POS_DOMAIN = 7'h12;
  localparam logic [6:0] POS_DECIDE = 7'h13;
  localparam logic [6:0] POS_CORR   = 7'h16;
  localparam logic [6:0] POS_RESV   = 7'h1e;
  localparam logic [6:0] POS_PORT   = 7'h2a;
  localparam logic [6:0] POS_SEQ    = 7'h2c;
  localparam logic [6:0] POS_ID_END = 7'h2e;
  localparam logic [6:0] POS_TXF    = 7'h12;
  localparam logic [6:0] POS_RXF    = 7'h1a;
  localparam logic [6:0] POS_TXB    = 7'h22;
  localparam logic [6:0] POS_RXB    = 7'h2a;
  localparam logic [3:0] SIZE_NONE  = 4'h0;
  localparam logic [3:0] SIZE_NS    = 4'h4;
  localparam logic [3:0] SIZE_TS    = 4'h8;

  // ---------------------------------------------------------------
  // frame check sequence
  // ---------------------------------------------------------------
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_WRITE  = 2'b01,
    ACT_WRSAVE = 2'b10
  } tsr_act_t;
endpackage

// ---- hw/tsr_fifo_if.sv ----
`timescale 1ns/1ps
interface tsr_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] wrData;
  logic             wrValid;
  logic             wrReady;
  logic [WIDTH-1:0] rdData;
  logic             rdValid;
  logic             rdReady;
  modport user  (output wrData, output wrValid, input wrReady,
                 input rdData, input rdValid, output rdReady);
  modport store (input wrData, input wrValid, output wrReady,
                 output rdData, output rdValid, input rdReady);
endinterface

// ---- hw/tsr_fifo.sv ----
`timescale 1ns/1ps
module tsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic  mclk,
  input wire logic  rst,
  // queue
  tsr_fifo_if.store q
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [PW:0]      count_r;
  logic             doWr;
  logic             doRd;

  function automatic logic [PW-1:0] ptrStep(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign q.wrReady = (count_r != (PW+1)'(DEPTH));
  assign q.rdValid = (count_r != '0);
  assign q.rdData  = mem[rdPtr_r];
  assign doWr      = q.wrValid && q.wrReady;
  assign doRd      = q.rdValid && q.rdReady;

  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_r] <= q.wrData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (doWr) begin
        wrPtr_r <= ptrStep(wrPtr_r);
      end
      if (doRd) begin
        rdPtr_r <= ptrStep(rdPtr_r);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (doWr && !doRd) begin
      count_r <= count_r + 1'b1;
    end else if (doRd && !doWr) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule

// ---- testbench/tsr_link_model.sv ----
`timescale 1ns/1ps
module tsr_link_model
  import tsr_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // delayed stream seen on the line side
  input  wire logic [DATA_W-1:0]  outData,
  input  wire logic               outValid,
  input  wire logic               outSof,
  input  wire logic               outEof,
  // stamp queue read side
  input  wire logic [ENTRY_W-1:0] tsData,
  input  wire logic               tsValid,
  output logic                    tsReady,
  // host pacing
  input  wire logic               stall
);
  // ---------------------------------------------------------------
  // captured traffic
  // ---------------------------------------------------------------
  logic [9:0]         rx[$];
  logic [ENTRY_W-1:0] entries[$];

  // ready moves only after an edge, so a slow host really holds off
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tsReady <= 1'b0;
    end else begin
      if (outValid) rx.push_back({outSof, outEof, outData});
      if (tsValid && tsReady) entries.push_back(tsData);
      tsReady <= !stall;
    end
  end
endmodule

// ---- testbench/tsr_rewrite_tb_top.sv ----
`timescale 1ns/1ps
module tsr_rewrite_tb_top
  import tsr_pkg::*;
();
  typedef logic [7:0] tsr_frame_t [64];

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic               mclk;
  logic               rst;
  logic               egressDir;
  logic [7:0]         cfgDomain;
  logic [2:0]         cfgMepLevel;
  logic [NS_W-1:0]    localCorrection;
  logic [NS_W-1:0]    asymmetry;
  logic               saveRxStamp;
  logic [TIME_W-1:0]  localTime;
  logic [DATA_W-1:0]  inData;
  logic               inValid;
  logic               inSof;
  logic               inEof;
  logic               streamReady;
  logic [DATA_W-1:0]  outData;
  logic               outValid;
  logic               outSof;
  logic               outEof;
  logic [ENTRY_W-1:0] tsData;
  logic               tsValid;
  logic               tsReady;
  logic               stall;
  tsr_frame_t         fr;
  tsr_frame_t         ex;
  int                 base;
  int                 nMismatch;
  int                 testsRun;

  tsr_rewrite_top i_tsr_rewrite_top (
    .mclk(mclk), .rst(rst), .egressDir(egressDir), .cfgDomain(cfgDomain),
    .cfgMepLevel(cfgMepLevel), .localCorrection(localCorrection), .asymmetry(asymmetry),
    .saveRxStamp(saveRxStamp), .localTime(localTime), .inData(inData), .inValid(inValid),
    .inSof(inSof), .inEof(inEof), .streamReady(streamReady), .outData(outData),
    .outValid(outValid), .outSof(outSof), .outEof(outEof), .tsData(tsData),
    .tsValid(tsValid), .tsReady(tsReady)
  );

  tsr_link_model i_tsr_link_model (
    .mclk(mclk), .rst(rst), .outData(outData), .outValid(outValid), .outSof(outSof),
    .outEof(outEof), .tsData(tsData), .tsValid(tsValid), .tsReady(tsReady), .stall(stall)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic tsr_frame_t setf(tsr_frame_t a, int p, logic [63:0] v, int nb);
    for (int k = 0; k < nb; k++) a[p+k] = v[8*(nb-1-k) +: 8];
    return a;
  endfunction

  function automatic logic [63:0] pk(tsr_frame_t a, int p, int nb);
    logic [63:0] v;
    v = 64'h0;
    for (int k = 0; k < nb; k++) v = {v[55:0], a[p+k]};
    return v;
  endfunction

  // fresh check sequence over the first 60 bytes
  function automatic tsr_frame_t seal(tsr_frame_t a);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 60; i++) begin
      c = c ^ {24'h0, a[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    c = ~c;
    for (int k = 0; k < 4; k++) a[60+k] = c[8*k +: 8];
    return a;
  endfunction

  task automatic chk(input logic [127:0] seen, input logic [127:0] want, input string msg);
    testsRun++;
    if (seen !== want) begin
      nMismatch++;
      $display("MISMATCH %0t %s: saw %0h want %0h", $time, msg, seen, want);
    end
  endtask

  task automatic conclude();
    if (nMismatch == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic mk(input logic [15:0] et, input logic [7:0] b14, input logic [7:0] b15,
                    input logic [7:0] dom);
    for (int i = 0; i < 64; i++) fr[i] = 8'(i * 7 + 3);
    fr = setf(fr, 12, {48'h0, et}, 2);
    fr[14] = b14;
    fr[15] = b15;
    fr[18] = dom;
    fr = seal(fr);
    ex = fr;
  endtask

  // one 64 byte frame in, whole frame compared on the way out
  task automatic runf(input logic [63:0] t);
    base = i_tsr_link_model.rx.size();
    ex = seal(ex);
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      inValid   <= 1'b1;
      inSof     <= (i == 0);
      inEof     <= (i == 63);
      inData    <= fr[i];
      localTime <= (i == 0) ? t : t + 64'h55;
    end
    @(posedge mclk);
    inValid <= 1'b0;
    inSof   <= 1'b0;
    inEof   <= 1'b0;
    repeat (DELAY_CYC + 4) @(posedge mclk);
    chk(i_tsr_link_model.rx.size() - base, 64, "length");
    chk(i_tsr_link_model.rx[base][9:8], 2'b10, "start flag");
    chk(i_tsr_link_model.rx[base+63][9:8], 2'b01, "end flag");
    for (int i = 0; i < 64; i++) chk(i_tsr_link_model.rx[base+i][7:0], ex[i], "byte");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_unmatched();
    egressDir <= 1'b0;
    mk(16'h0800, 8'h00, 8'h00, 8'h00);
    runf({32'h1, 32'h100});
    mk(ETYPE_PTP, {4'h0, MSG_SYNC}, 8'h02, cfgDomain + 8'h1);
    runf({32'h1, 32'h200});
    mk(ETYPE_OAM, {cfgMepLevel + 3'h1, 5'h0}, OP_DMM, 8'h00);
    runf({32'h1, 32'h300});
  endtask

  task automatic t_ing_ptp();
    logic [63:0] t;
    t = {32'h9, 32'h3b9a_0010};
    egressDir <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      mk(ETYPE_PTP, {4'h0, 4'(m)}, 8'h02, cfgDomain);
      ex = setf(ex, 30, {32'h0, t[31:0] - localCorrection}, 4);
      if (m == 0) ex = setf(ex, 22, pk(fr, 22, 8) + {{32{asymmetry[31]}}, asymmetry}, 8);
      runf(t);
    end
  endtask

  task automatic t_oam();
    logic [7:0]  op;
    logic [31:0] ns;
    int          pos;
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 3; k++) begin
        op = (k == 0) ? OP_1DM : ((k == 1) ? OP_DMM : OP_DMR);
        egressDir <= d[0];
        mk(ETYPE_OAM, {cfgMepLevel, 5'h0}, op, 8'h00);
        ns  = d ? 32'h1000_0000 + localCorrection : 32'h1000_0000 - localCorrection;
        pos = d ? ((k == 2) ? 34 : 18) : ((k == 2) ? 42 : 26);
        ex  = setf(ex, pos, {32'h2a, ns}, 8);
        runf({32'h2a, 32'h1000_0000});
      end
    end
  endtask

  // nine save frames against a stalled host: eight fill, one waits
  task automatic t_egr_fill();
    logic [31:0] st;
    egressDir   <= 1'b1;
    saveRxStamp <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      mk(ETYPE_PTP, {7'h0, k[0]}, 8'h02, cfgDomain);
      fr = setf(fr, 30, 32'hab00_0000 + 32'(k), 4);
      fr = setf(fr, 44, 64'(k), 2);
      fr = seal(fr);
      ex = setf(fr, 30, 64'h0, 4);
      runf({32'h3, 32'h2000_0000 + 32'(k) * 32'h100});
    end
    chk(streamReady, 1'b0, "full queue");
    stall <= 1'b0;
    for (int w = 0; w < 60 && i_tsr_link_model.entries.size() < 9; w++) @(posedge mclk);
    // let the last pop settle before looking at queue flags
    @(negedge mclk);
    for (int k = 0; k < 9; k++) begin
      st = 32'h2000_0000 + 32'(k) * 32'h100 + localCorrection - (k[0] ? asymmetry : 32'h0);
      chk(i_tsr_link_model.entries[k], {st, 32'hab00_0000 + 32'(k), 16'(k), fr[42], fr[43],
          cfgDomain, 7'h0, k[0]}, "entry");
    end
    chk(streamReady, 1'b1, "ready again");
    chk(tsValid, 1'b0, "queue empty");
  endtask

  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  always #50 mclk = ~mclk;

  initial begin
    mclk            = 1'b0;
    rst             = 1'b1;
    egressDir       = 1'b0;
    cfgDomain       = 8'h05;
    cfgMepLevel     = 3'h4;
    localCorrection = 32'h0000_0123;
    asymmetry       = 32'hffff_fff0;
    saveRxStamp     = 1'b0;
    localTime       = 64'h0;
    inData          = 8'h00;
    inValid         = 1'b0;
    inSof           = 1'b0;
    inEof           = 1'b0;
    stall           = 1'b1;
    nMismatch       = 0;
    testsRun        = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_unmatched();
    t_ing_ptp();
    t_oam();
    t_egr_fill();
    conclude();
  end

  // twenty frames of eighty-five cycles each, with wide margin
  initial begin
    repeat (10000) @(posedge mclk);
    nMismatch++;
    conclude();
  end
endmodule
